/* src/pld_pkg.sv */
// What this block does
// RL1 - Eight-bit ALU finishes every operation in one clock cycle, with conditions.
// RL2 - Both accumulators feed the ALU and comparators and take ALU results.
// RL3 - Both data registers feed ALU and comparators, never take ALU results.
// RL4 - Two four-byte queues load registers or capture accumulator or ALU values.
// RL5 - Eight sixteen-bit configuration words define the datapath function.
// RL6 - Configuration address comes from routing every cycle.
// RL7 - ALU does increment, decrement, add, subtract, and, or, xor, pass.
// RL8 - Shift left, shift right, nibble swap and OR mask follow the ALU.
// RL9 - Two masked comparators choose operands from accumulators and data registers.
// RL10 - Zero, all-ones and overflow conditions are generated as well.
// RL11 - A configurable subset of conditions drives the routing outputs.
// RL12 - Programmable most significant bit for arithmetic and shifts.
// RL13 - One CRC or pseudo-random step per cycle for any polynomial.
// RL14 - Each queue is input or output; bus respects that direction.
// RL15 - Queue status is selectable as datapath outputs.
// RL16 - Conditions, carries and shift data chain to neighbouring cells.
// RL17 - Carry and shift-out are registered and selectable later.
// RL18 - Six routing inputs and six routing outputs.
// RL19 - Every control register bit drives a routing signal.
// RL20 - Status register is read-only and shows routing signals.
// RL21 - Capture status bits latch events until read, then clear.
// RL22 - Each sub-block has its own clock enable control.
// RL23 - Addressed configuration word sets operation and destination each cycle.
`default_nettype none
package pld_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [4:0] ADR_ACC0 = 5'h00;
  localparam logic [4:0] ADR_ACC1 = 5'h01;
  localparam logic [4:0] ADR_DAT0 = 5'h02;
  localparam logic [4:0] ADR_DAT1 = 5'h03;
  localparam logic [4:0] ADR_Q0 = 5'h04;
  localparam logic [4:0] ADR_Q1 = 5'h05;
  localparam logic [4:0] ADR_MASK = 5'h06;
  localparam logic [4:0] ADR_MSB = 5'h07;
  localparam logic [4:0] ADR_POLY = 5'h08;
  localparam logic [4:0] ADR_CMSK0 = 5'h09;
  localparam logic [4:0] ADR_CMSK1 = 5'h0a;
  localparam logic [4:0] ADR_QDIR = 5'h0b;
  localparam logic [4:0] ADR_OSEL = 5'h0c;
  localparam logic [4:0] ADR_CTRL = 5'h0d;
  localparam logic [4:0] ADR_STAT = 5'h0e;
  localparam logic [4:0] ADR_CAPM = 5'h0f;
  localparam logic [4:0] ADR_CLKEN = 5'h10;
  localparam logic [4:0] ADR_CFG = 5'h18;
  // ----------------------------------------
  // Reset values and sizes
  // ----------------------------------------
  localparam logic [7:0] RST_MASK = 8'hff;
  localparam logic [2:0] RST_MSB = 3'h7;
  localparam logic [7:0] RST_CMSK = 8'hff;
  localparam logic [3:0] RST_CLKEN = 4'hf;
  localparam int CFG_WORDS = 8;
  localparam int Q_DEPTH = 4;
  localparam int ROUTE_W = 6;
  // ----------------------------------------
  // Configuration word layout
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_PASS, OP_INC, OP_DEC, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR
  } pld_op_t;
  typedef enum logic [1:0] {
    SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP
  } pld_shift_t;
  typedef struct packed {
    pld_op_t op;        // 15:13
    logic src_a;        // 12 accumulator one when set
    logic [1:0] src_b;  // 11:10 data0, data1, queue, other acc
    pld_shift_t shift;  // 9:8
    logic [1:0] dest;   // 7:6 none, acc0, acc1
    logic [1:0] cin;    // 5:4 zero, one, registered, chain
    logic crc;          // 3
    logic mask_en;      // 2
    logic [1:0] qwr;    // 1:0 bit0 queue0 write, bit1 queue1 write
  } pld_cfg_t;
  typedef struct packed {
    logic carry;
    logic shift;
    logic cmp_eq;
    logic cmp_lt;
  } pld_chain_t;
endpackage
`default_nettype wire

/* src/pld_datapath.sv */
// Strobed register access and the register addresses are this design's own decisions.
`default_nettype none
module pld_datapath #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [W-1:0] reg_rdata,
  // Routing matrix
  input wire logic [pld_pkg::ROUTE_W-1:0] route_in,
  output logic [pld_pkg::ROUTE_W-1:0] route_out,
  output logic [W-1:0] ctrl_out,
  input wire logic [W-1:0] status_in,
  output logic [3:0] clk_en,
  // Chaining
  input wire pld_pkg::pld_chain_t chain_in,
  output pld_pkg::pld_chain_t chain_out
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] cfg_ram [pld_pkg::CFG_WORDS];
  logic [W-1:0] acc [2];
  logic [W-1:0] dat [2];
  logic [W-1:0] q_mem [2][pld_pkg::Q_DEPTH];
  logic [1:0] q_rp [2];
  logic [1:0] q_wp [2];
  logic [2:0] q_cnt [2];
  logic [W-1:0] out_mask, poly, ctrl, cap_mask, cap;
  logic [W-1:0] cmask [2];
  logic [2:0] msb;
  logic [1:0] qdir;
  logic [5:0] osel;
  logic carry_q, shout_q;
  logic [pld_pkg::ROUTE_W-1:0] rin_s1, rin_s2;
  logic [W-1:0] st_s1, st_s2;
  // ----------------------------------------
  // Routing inputs synchronised
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    rin_s1 <= route_in;
    rin_s2 <= rin_s1;
    st_s1 <= status_in;
    st_s2 <= st_s1;
  end
  // ----------------------------------------
  // Configuration select
  // ----------------------------------------
  wire logic [2:0] cfg_addr = rin_s2[2:0]; // RL6 RL18
  wire logic sin = rin_s2[3]; // RL18
  wire pld_pkg::pld_cfg_t cfg = pld_pkg::pld_cfg_t'(cfg_ram[cfg_addr]); // RL5
  // Run gate: datapath clock enable and routing enable bit
  wire logic dp_run = clk_en[2] & rin_s2[4]; // RL22
  // ----------------------------------------
  // Operand select
  // ----------------------------------------
  wire logic [W-1:0] opa = acc[cfg.src_a]; // RL2
  logic [W-1:0] opb;
  always_comb begin
    unique case (cfg.src_b)
      2'd0: opb = dat[0]; // RL3
      2'd1: opb = dat[1]; // RL3
      2'd2: opb = q_mem[0][q_rp[0]]; // RL4
      default: opb = acc[~cfg.src_a];
    endcase
  end
  logic cin;
  always_comb begin
    unique case (cfg.cin)
      2'd0: cin = 1'b0;
      2'd1: cin = 1'b1;
      2'd2: cin = carry_q; // RL17
      default: cin = chain_in.carry; // RL16
    endcase
  end
  // ----------------------------------------
  // ALU
  // ----------------------------------------
  function automatic logic [W-1:0] msb_mask(input logic [2:0] m);
    msb_mask = W'((9'h2 << m) - 9'h1);
  endfunction
  wire logic [W-1:0] vmask = msb_mask(msb); // RL12
  logic [W:0] sum;
  always_comb begin
    unique case (cfg.op) // RL1 RL7
      pld_pkg::OP_PASS: sum = {1'b0, opa};
      pld_pkg::OP_INC: sum = {1'b0, opa} + (W+1)'(1);
      pld_pkg::OP_DEC: sum = {1'b0, opa} - (W+1)'(1);
      pld_pkg::OP_ADD: sum = {1'b0, opa} + {1'b0, opb} + (W+1)'(cin);
      pld_pkg::OP_SUB: sum = {1'b0, opa} - {1'b0, opb} - (W+1)'(cin);
      pld_pkg::OP_AND: sum = {1'b0, opa & opb};
      pld_pkg::OP_OR: sum = {1'b0, opa | opb};
      pld_pkg::OP_XOR: sum = {1'b0, opa ^ opb};
    endcase
  end
  wire logic [W-1:0] alu_v = sum[W-1:0] & vmask;
  // Carry taken at the programmed msb, so narrow counters wrap correctly
  wire logic carry = (cfg.op inside {pld_pkg::OP_AND, pld_pkg::OP_OR,
    pld_pkg::OP_XOR, pld_pkg::OP_PASS}) ? 1'b0 :
    ((msb == 3'(W-1)) ? sum[W] : sum[msb + 3'd1]); // RL12
  wire logic ovf = (opa[msb] == (opb[msb] ^ (cfg.op == pld_pkg::OP_SUB)))
    & (alu_v[msb] != opa[msb]) & (cfg.op inside {pld_pkg::OP_ADD,
    pld_pkg::OP_SUB}); // RL10
  // CRC step: shift left at msb, feed back polynomial
  wire logic fb = alu_v[msb] ^ sin;
  wire logic [W-1:0] crc_v = ((alu_v << 1) ^ (fb ? poly : '0)) & vmask; // RL13
  logic [W-1:0] sh_v;
  logic shout;
  always_comb begin
    shout = 1'b0;
    unique case (cfg.shift) // RL8
      pld_pkg::SH_NONE: sh_v = alu_v;
      pld_pkg::SH_LEFT: begin
        sh_v = ((alu_v << 1) | W'(sin)) & vmask;
        shout = alu_v[msb];
      end
      pld_pkg::SH_RIGHT: begin
        sh_v = (alu_v >> 1) | (W'(chain_in.shift) << msb); // RL16
        shout = alu_v[0];
      end
      pld_pkg::SH_SWAP: sh_v = {alu_v[3:0], alu_v[7:4]};
    endcase
  end
  wire logic [W-1:0] res0 = cfg.crc ? crc_v : sh_v;
  wire logic [W-1:0] result = cfg.mask_en ? (res0 | out_mask) : res0; // RL8
  // ----------------------------------------
  // Conditions
  // ----------------------------------------
  wire logic [W-1:0] c0a = acc[0] & cmask[0];
  wire logic [W-1:0] c0b = dat[0] & cmask[0];
  wire logic [W-1:0] c1a = acc[1] & cmask[1];
  wire logic [W-1:0] c1b = (cfg.src_b[0] ? acc[0] : dat[1]) & cmask[1];
  wire logic eq0 = (c0a == c0b); // RL9
  wire logic lt0 = (c0a < c0b); // RL9
  wire logic eq1 = (c1a == c1b) & chain_in.cmp_eq; // RL9 RL16
  wire logic lt1 = (c1a < c1b) | (chain_in.cmp_lt & (c1a == c1b));
  wire logic z0 = (acc[0] == '0); // RL10
  wire logic z1 = (acc[1] == '0);
  wire logic ff0 = (acc[0] == vmask); // RL10
  wire logic ff1 = (acc[1] == vmask);
  wire logic [1:0] q_full, q_empty;
  wire logic [15:0] conds = {shout_q, q_full, q_empty, carry_q, ovf,
    ff1, ff0, z1, z0, lt1, eq1, lt0, eq0, 1'b0}; // RL15
  genvar gi;
  generate
    for (gi = 0; gi < pld_pkg::ROUTE_W; gi++) begin : g_out
      wire logic [3:0] s = (gi == 5) ? 4'h0 : osel[3:0] + 4'(gi);
      assign route_out[gi] = (gi == 5) ? shout_q : conds[s]; // RL11 RL18
    end
  endgenerate
  assign chain_out = '{carry: carry, shift: shout, cmp_eq: eq1, cmp_lt: lt1};
  // ----------------------------------------
  // Queues
  // ----------------------------------------
  wire logic wr_hit = reg_wr;
  wire logic [1:0] bus_qw, bus_qr, dp_qw, dp_qr, q_push, q_pop;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_q
      wire logic is_q = (reg_addr == (pld_pkg::ADR_Q0 + 5'(gi)));
      assign q_full[gi] = (q_cnt[gi] == 3'(pld_pkg::Q_DEPTH));
      assign q_empty[gi] = (q_cnt[gi] == 3'd0);
      // Bus may only feed an input queue and drain an output one
      assign bus_qw[gi] = reg_wr & is_q & ~qdir[gi] & ~q_full[gi]; // RL14
      assign bus_qr[gi] = reg_rd & is_q & qdir[gi] & ~q_empty[gi]; // RL14
      assign dp_qw[gi] = dp_run & cfg.qwr[gi] & qdir[gi] & ~q_full[gi];
      assign dp_qr[gi] = dp_run & ~qdir[gi] & ~q_empty[gi] &
        (gi == 0 ? cfg.src_b == 2'd2 : cfg.dest == 2'd3); // RL4
      assign q_push[gi] = bus_qw[gi] | dp_qw[gi];
      assign q_pop[gi] = bus_qr[gi] | dp_qr[gi];
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          q_rp[gi] <= 2'd0;
          q_wp[gi] <= 2'd0;
          q_cnt[gi] <= 3'd0;
        end else begin
          if (q_push[gi]) q_wp[gi] <= q_wp[gi] + 2'd1;
          if (q_pop[gi]) q_rp[gi] <= q_rp[gi] + 2'd1;
          q_cnt[gi] <= q_cnt[gi] + 3'(q_push[gi]) - 3'(q_pop[gi]);
        end
      end
      // Output queue captures accumulator 0 for queue 0, ALU for queue 1
      always_ff @(posedge core_clk) begin
        if (q_push[gi]) begin
          q_mem[gi][q_wp[gi]] <= bus_qw[gi] ? reg_wdata
            : (gi == 0 ? acc[0] : result); // RL4
        end
      end
    end
  endgenerate
  // ----------------------------------------
  // Working registers
  // ----------------------------------------
  wire logic [W-1:0] q1_head = q_mem[1][q_rp[1]];
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      acc[0] <= '0;
      acc[1] <= '0;
      dat[0] <= '0;
      dat[1] <= '0;
      carry_q <= 1'b0;
      shout_q <= 1'b0;
    end else begin
      if (dp_run) begin
        carry_q <= carry; // RL17
        shout_q <= shout; // RL17
        if (cfg.dest == 2'd1) acc[0] <= result; // RL2 RL23
        if (cfg.dest == 2'd2) acc[1] <= result; // RL2 RL23
        if (dp_qr[1]) dat[1] <= q1_head; // RL4
      end
      if (wr_hit && reg_addr == pld_pkg::ADR_ACC0) acc[0] <= reg_wdata;
      if (wr_hit && reg_addr == pld_pkg::ADR_ACC1) acc[1] <= reg_wdata;
      if (wr_hit && reg_addr == pld_pkg::ADR_DAT0) dat[0] <= reg_wdata;
      if (wr_hit && reg_addr == pld_pkg::ADR_DAT1) dat[1] <= reg_wdata;
    end
  end
  // ----------------------------------------
  // Config and control registers
  // ----------------------------------------
  wire logic cfg_hit = wr_hit && (reg_addr[4:3] == pld_pkg::ADR_CFG[4:3]);
  logic cfg_hi;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_mask <= pld_pkg::RST_MASK;
      msb <= pld_pkg::RST_MSB;
      poly <= '0;
      cmask[0] <= pld_pkg::RST_CMSK;
      cmask[1] <= pld_pkg::RST_CMSK;
      qdir <= 2'b00;
      osel <= '0;
      ctrl <= '0;
      cap_mask <= '0;
      clk_en <= pld_pkg::RST_CLKEN;
      cfg_hi <= 1'b0;
    end else if (wr_hit) begin
      unique case (reg_addr)
        pld_pkg::ADR_MASK: out_mask <= reg_wdata;
        pld_pkg::ADR_MSB: msb <= reg_wdata[2:0]; // RL12
        pld_pkg::ADR_POLY: poly <= reg_wdata;
        pld_pkg::ADR_CMSK0: cmask[0] <= reg_wdata;
        pld_pkg::ADR_CMSK1: cmask[1] <= reg_wdata;
        pld_pkg::ADR_QDIR: qdir <= reg_wdata[1:0]; // RL14
        pld_pkg::ADR_OSEL: osel <= reg_wdata[5:0]; // RL11
        pld_pkg::ADR_CTRL: ctrl <= reg_wdata; // RL19
        pld_pkg::ADR_CAPM: cap_mask <= reg_wdata;
        pld_pkg::ADR_CLKEN: {cfg_hi, clk_en} <= {reg_wdata[7], reg_wdata[3:0]};
        default: ;
      endcase
    end
  end
  // Config words written a byte at a time; bit 7 of clock reg picks half
  always_ff @(posedge core_clk) begin
    if (cfg_hit) begin
      if (cfg_hi) cfg_ram[reg_addr[2:0]][15:8] <= reg_wdata; // RL5
      else cfg_ram[reg_addr[2:0]][7:0] <= reg_wdata;
    end
  end
  // Control outputs are forced to zero while the control unit clock is off
  assign ctrl_out = ctrl & {W{clk_en[3]}}; // RL19 RL22
  // ----------------------------------------
  // Status capture
  // ----------------------------------------
  wire logic st_rd = reg_rd && reg_addr == pld_pkg::ADR_STAT;
  always_ff @(posedge core_clk) begin
    if (!rst_n) cap <= '0;
    else cap <= ((st_rd ? '0 : cap) | st_s2) & cap_mask; // RL21
  end
  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [W-1:0] next_rdata;
  always_comb begin
    unique case (reg_addr)
      pld_pkg::ADR_ACC0: next_rdata = acc[0];
      pld_pkg::ADR_ACC1: next_rdata = acc[1];
      pld_pkg::ADR_DAT0: next_rdata = dat[0];
      pld_pkg::ADR_DAT1: next_rdata = dat[1];
      pld_pkg::ADR_Q0: next_rdata = bus_qr[0] ? q_mem[0][q_rp[0]] : '0;
      pld_pkg::ADR_Q1: next_rdata = bus_qr[1] ? q1_head : '0;
      pld_pkg::ADR_MASK: next_rdata = out_mask;
      pld_pkg::ADR_MSB: next_rdata = W'(msb);
      pld_pkg::ADR_POLY: next_rdata = poly;
      pld_pkg::ADR_CMSK0: next_rdata = cmask[0]; // RL9
      pld_pkg::ADR_CMSK1: next_rdata = cmask[1]; // RL9
      pld_pkg::ADR_QDIR: next_rdata = W'({2'b0, q_full, q_empty, qdir});
      pld_pkg::ADR_OSEL: next_rdata = W'(osel);
      pld_pkg::ADR_CTRL: next_rdata = ctrl;
      pld_pkg::ADR_STAT: next_rdata = (st_s2 & ~cap_mask) | cap; // RL20
      pld_pkg::ADR_CAPM: next_rdata = cap_mask;
      pld_pkg::ADR_CLKEN: next_rdata = W'({cfg_hi, 3'b0, clk_en});
      default: next_rdata = '0;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) reg_rdata <= '0;
    else reg_rdata <= reg_rd ? next_rdata : '0;
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  acc_dest_a: assert property (dp_run && cfg.dest == 2'd1 && !wr_hit // RL23
    |=> acc[0] == $past(result)) else $error("acc0 not updated");
  dat_keep_a: assert property (!wr_hit && !dp_qr[1] // RL3
    |=> $stable(dat[1])) else $error("data reg changed by ALU");
  q_bound_a: assert property (q_cnt[0] <= 3'd4 && q_cnt[1] <= 3'd4) // RL4
    else $error("queue over depth");
  // A datapath push into an output queue is legal in the same cycle
  q_dir_a: assert property (qdir[0] && reg_wr && !dp_qw[0] // RL14
    && reg_addr == pld_pkg::ADR_Q0 |=> $stable(q_wp[0]))
    else $error("bus wrote output queue");
  cap_hold_a: assert property (cap[0] && !st_rd // RL21
    |=> cap[0] || !cap_mask[0]) else $error("capture lost");
  carry_reg_a: assert property (dp_run |=> carry_q == $past(carry)) // RL17
    else $error("carry not registered");
  ctrl_drv_a: assert property (clk_en[3] |-> ctrl_out == ctrl) // RL19
    else $error("control not driven");
  rd_late_a: assert property (reg_rd && reg_addr == pld_pkg::ADR_CTRL // RL20
    && !wr_hit |=> reg_rdata == $past(ctrl)) else $error("bad read");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0) // RL20
    else $error("read data outside read cycle");
  q_fill_c: cover property (q_full[0]);
  cap_c: cover property (cap != '0 ##1 st_rd);
  crc_c: cover property (dp_run && cfg.crc && cfg.dest != 2'd0);
endmodule
`default_nettype wire

/* verification/pld_bus_model.sv */
`default_nettype none
// ----------------------------------------
// Processor side of the register port
// ----------------------------------------
module pld_bus_model (
  // Clock
  input wire logic core_clk,
  // Register port
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One-cycle strobe; the slave never stalls, so no wait loop
  task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* verification/pld_tb_top.sv */
`default_nettype none
module programmable_logic_datapath_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk;
  logic rst_n;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [5:0] route_in;
  logic [5:0] route_out;
  logic [7:0] ctrl_out;
  logic [7:0] status_in;
  logic [3:0] clk_en;
  pld_pkg::pld_chain_t chain_in;
  pld_pkg::pld_chain_t chain_out;
  int n_mismatch;
  int num_checks;
  int cycles;
  logic [7:0] lfsr;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] d;

  pld_datapath #(.W(8)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .route_in(route_in), .route_out(route_out),
    .ctrl_out(ctrl_out), .status_in(status_in), .clk_en(clk_en),
    .chain_in(chain_in), .chain_out(chain_out)
  );
  pld_bus_model bm (
    .core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic end_of_test;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Whole run needs about 650 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic check(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] ad, input logic [7:0] v);
    bm.bus_wr(ad, v);
  endtask
  task automatic rchk(input string nm, input logic [4:0] ad,
                      input logic [7:0] e);
    bm.bus_rd(ad, d);
    check(nm, e, d);
  endtask
  task automatic settle;
    @(posedge core_clk);
    #1;
  endtask
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [15:0] mk(input int op, input int sb,
      input int sh, input int ds, input int ci, input int qw);
    pld_pkg::pld_cfg_t c;
    c = '0;
    c.op = pld_pkg::pld_op_t'(op[2:0]);
    c.src_b = sb[1:0];
    c.shift = pld_pkg::pld_shift_t'(sh[1:0]);
    c.dest = ds[1:0];
    c.cin = ci[1:0];
    c.qwr = qw[1:0];
    return c;
  endfunction
  function automatic logic [7:0] alu(input int op, input logic [7:0] x,
                                     input logic [7:0] y);
    case (op)
      1: return x + 8'h01;
      2: return x - 8'h01;
      3: return x + y;
      4: return x - y;
      5: return x & y;
      6: return x | y;
      7: return x ^ y;
      default: return x;
    endcase
  endfunction
  function automatic logic [7:0] shf(input int s, input logic [7:0] x);
    case (s)
      1: return {x[6:0], 1'b0};
      2: return {1'b0, x[7:1]};
      default: return {x[3:0], x[7:4]};
    endcase
  endfunction
  // One CRC step on a four-bit register, serial input held low
  function automatic logic [7:0] crc4(input logic [7:0] x,
                                      input logic [7:0] p);
    logic [3:0] r;
    r = {x[2:0], 1'b0};
    if (x[3]) r = r ^ p[3:0];
    return {4'h0, r};
  endfunction
  // Low byte with select clear, high byte with select set
  task automatic cfg(input logic [2:0] n, input logic [15:0] w);
    wr(pld_pkg::ADR_CLKEN, 8'h0f);
    wr(pld_pkg::ADR_CFG | {2'b00, n}, w[7:0]);
    wr(pld_pkg::ADR_CLKEN, 8'h8f);
    wr(pld_pkg::ADR_CFG | {2'b00, n}, w[15:8]);
    wr(pld_pkg::ADR_CLKEN, 8'h0f);
  endtask
  // Address settles through the synchroniser before one run cycle
  task automatic step(input logic [2:0] n);
    @(posedge core_clk);
    route_in <= {3'b000, n};
    repeat (4) @(posedge core_clk);
    route_in[4] <= 1'b1;
    @(posedge core_clk);
    route_in[4] <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    route_in = 6'h00;
    status_in = 8'h00;
    chain_in = '0;
    chain_in.cmp_eq = 1'b1;
    rst_n = 1'b0;
    lfsr = 8'h0d;
    n_mismatch = 0;
    num_checks = 0;
    cycles = 0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    rchk("mask", pld_pkg::ADR_MASK, pld_pkg::RST_MASK);
    rchk("msb", pld_pkg::ADR_MSB, {5'h00, pld_pkg::RST_MSB});
    rchk("cmask0", pld_pkg::ADR_CMSK0, pld_pkg::RST_CMSK);
    rchk("cmask1", pld_pkg::ADR_CMSK1, pld_pkg::RST_CMSK);
    rchk("qflags", pld_pkg::ADR_QDIR, 8'h0c);
    rchk("acc0", pld_pkg::ADR_ACC0, 8'h00);
    rchk("unmapped", 5'h11, 8'h00);
    check("clk_en", {4'h0, pld_pkg::RST_CLKEN}, {4'h0, clk_en});
    for (int i = 0; i < 8; i++) cfg(3'(i), mk(0, 0, 0, 0, 0, 0));
    // Every operation into acc1; data register must not change
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      a = lfsr;
      lfsr = nxt(lfsr);
      b = lfsr;
      if (i == 3) begin
        a = 8'hff;
        b = 8'h01;
      end
      wr(pld_pkg::ADR_ACC0, a);
      wr(pld_pkg::ADR_DAT0, b);
      cfg(3'd0, mk(i, 0, 0, 2, 0, 0));
      step(3'd0);
      rchk("alu", pld_pkg::ADR_ACC1, alu(i, a, b));
      rchk("dat0", pld_pkg::ADR_DAT0, b);
    end
    for (int s = 1; s < 4; s++) begin
      lfsr = nxt(lfsr);
      wr(pld_pkg::ADR_ACC0, lfsr);
      cfg(3'd1, mk(0, 0, s, 2, 0, 0));
      step(3'd1);
      rchk("shift", pld_pkg::ADR_ACC1, shf(s, lfsr));
    end
    // Carry kept from one step and used by the next
    wr(pld_pkg::ADR_ACC0, 8'hff);
    wr(pld_pkg::ADR_DAT0, 8'h01);
    cfg(3'd0, mk(3, 0, 0, 1, 0, 0));
    cfg(3'd1, mk(3, 0, 0, 1, 2, 0));
    step(3'd0);
    rchk("wrap", pld_pkg::ADR_ACC0, 8'h00);
    step(3'd1);
    rchk("carry", pld_pkg::ADR_ACC0, 8'h02);
    // Input queue filled past its depth
    for (int i = 0; i < 5; i++) wr(pld_pkg::ADR_Q0, 8'h40 + 8'(i));
    rchk("qflags", pld_pkg::ADR_QDIR, 8'h18);
    wr(pld_pkg::ADR_OSEL, 8'h0b);
    settle();
    check("qroute", 8'h06, {4'h0, route_out[3:0]});
    rchk("inq rd", pld_pkg::ADR_Q0, 8'h00);
    rchk("qflags", pld_pkg::ADR_QDIR, 8'h18);
    // Output queue takes the result; bus write is ignored
    wr(pld_pkg::ADR_QDIR, 8'h02);
    wr(pld_pkg::ADR_Q1, 8'h55);
    wr(pld_pkg::ADR_ACC0, 8'h21);
    wr(pld_pkg::ADR_DAT0, 8'h10);
    cfg(3'd2, mk(3, 0, 0, 0, 0, 2));
    step(3'd2);
    rchk("outq", pld_pkg::ADR_Q1, 8'h31);
    rchk("outq", pld_pkg::ADR_Q1, 8'h00);
    // Queue 0 turned to output: bus drains it, bus writes are refused
    wr(pld_pkg::ADR_QDIR, 8'h03);
    rchk("q0 head", pld_pkg::ADR_Q0, 8'h40);
    wr(pld_pkg::ADR_Q0, 8'h77);
    rchk("qflags", pld_pkg::ADR_QDIR, 8'h0b);
    rchk("q0 next", pld_pkg::ADR_Q0, 8'h41);
    // Zero and all-ones conditions on the routing outputs
    wr(pld_pkg::ADR_ACC0, 8'h00);
    wr(pld_pkg::ADR_ACC1, 8'hff);
    wr(pld_pkg::ADR_OSEL, 8'h05);
    settle();
    check("cond", 8'h09, {4'h0, route_out[3:0]});
    wr(pld_pkg::ADR_CTRL, 8'h5a);
    settle();
    check("ctrl", 8'h5a, ctrl_out);
    rchk("ctrl rd", pld_pkg::ADR_CTRL, 8'h5a);
    wr(pld_pkg::ADR_CLKEN, 8'h07);
    settle();
    check("clk_en", 8'h07, {4'h0, clk_en});
    check("ctrl", 8'h00, ctrl_out);
    wr(pld_pkg::ADR_CLKEN, 8'h0f);
    // One-cycle event held until read, live bits pass through
    wr(pld_pkg::ADR_CAPM, 8'h01);
    @(posedge core_clk);
    status_in <= 8'ha1;
    @(posedge core_clk);
    status_in <= 8'ha0;
    repeat (4) @(posedge core_clk);
    rchk("status", pld_pkg::ADR_STAT, 8'ha1);
    rchk("status", pld_pkg::ADR_STAT, 8'ha0);
    // Four-bit counter wraps at the programmed msb and sets the carry
    wr(pld_pkg::ADR_MSB, 8'h03);
    wr(pld_pkg::ADR_POLY, 8'h03);
    wr(pld_pkg::ADR_ACC0, 8'h0f);
    cfg(3'd3, mk(1, 0, 0, 1, 0, 0));
    step(3'd3);
    rchk("msb wrap", pld_pkg::ADR_ACC0, 8'h00);
    wr(pld_pkg::ADR_OSEL, 8'h0a);
    settle();
    check("carry_q", 8'h01, {7'h00, route_out[0]});
    wr(pld_pkg::ADR_ACC0, 8'h09);
    cfg(3'd3, mk(0, 0, 0, 1, 0, 0) | 16'h0008);
    step(3'd3);
    rchk("crc", pld_pkg::ADR_ACC0, crc4(8'h09, 8'h03));
    wr(pld_pkg::ADR_MSB, 8'h07);
    // Masked compare, signed overflow on subtract, OR mask on result
    wr(pld_pkg::ADR_ACC0, 8'h7f);
    wr(pld_pkg::ADR_DAT0, 8'h81);
    wr(pld_pkg::ADR_OSEL, 8'h01);
    settle();
    check("cmp", 8'h02, {6'h00, route_out[1:0]});
    wr(pld_pkg::ADR_CMSK0, 8'h01);
    settle();
    check("cmp mask", 8'h01, {6'h00, route_out[1:0]});
    wr(pld_pkg::ADR_MASK, 8'h01);
    cfg(3'd5, mk(4, 0, 0, 2, 0, 0) | 16'h0004);
    step(3'd5);
    rchk("or mask", pld_pkg::ADR_ACC1, alu(4, 8'h7f, 8'h81) | 8'h01);
    wr(pld_pkg::ADR_OSEL, 8'h09);
    settle();
    check("ovf", 8'h01, {7'h00, route_out[0]});
    check("chain", 8'h01, {7'h00, chain_out.carry});
    end_of_test();
  end
endmodule
`default_nettype wire
